// ---- inc/dic_pkg.sv ----
// Purpose: constants of the two-level interrupt controller
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   bit 0 is the fast-level summary, bit 1 the programmed source
// Behaviour
// [RL1] Normal enabled status is raw AND mask
// [RL2] No priority encoder, no vector generation
// [RL3] Normal request is OR of enabled status
// [RL4] Fast path mirrors normal path, own registers
// [RL5] Fast bits 31..1 ORed to request, bit0
// [RL6] Fast enable write clears same normal bit
// [RL7] Normal enable write clears same fast bit
// [RL8] Source may be masked at both levels
// [RL9] Config bit 2 drives fast bit 1
// [RL10] Config bit 1 drives normal bit 1
// [RL11] Programmed interrupts bypass the enable masks
// [RL12] Sources hold requests past minimum latency
// [RL13] Raw status follows peripheral request, read-only
// [RL14] Mask one passes request, zero blocks
// [RL15] Mask-clear port clears written ones only
// [RL16] Fixed bit map, bits 6, 15 reserved
// [RL17] Reserved bits read zero, writes ignored
// [RL18] Requests are registered levels
package dic_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          SRC_LO        = 2;
    localparam int          SRC_HI        = 19;
    localparam int          SRC_W         = SRC_HI - SRC_LO + 1;

    localparam logic [7:0]  OFS_NRM_RAW   = 8'h00;
    localparam logic [7:0]  OFS_NRM_EN    = 8'h04;
    localparam logic [7:0]  OFS_NRM_CLR   = 8'h08;
    localparam logic [7:0]  OFS_NRM_STA   = 8'h0c;
    localparam logic [7:0]  OFS_FST_RAW   = 8'h10;
    localparam logic [7:0]  OFS_FST_EN    = 8'h14;
    localparam logic [7:0]  OFS_FST_CLR   = 8'h18;
    localparam logic [7:0]  OFS_FST_STA   = 8'h1c;
    localparam logic [7:0]  OFS_PROG      = 8'h20;

    localparam int          BIT_FAST_OR   = 0;
    localparam int          BIT_PROG      = 1;
    localparam int          BIT_PROG_NRM  = 1;
    localparam int          BIT_PROG_FST  = 2;

    // Peripheral positions 2..19 without reserved 6 and 15
    localparam logic [31:0] SRC_BITS      = 32'h000f_7fbc;
    localparam logic [31:0] EN_BITS       = 32'h000f_7fbc;
    localparam logic [1:0]  PROG_BITS     = 2'h3;

    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [1:0]  RST_PROG      = 2'h0;
    localparam logic [SRC_W-1:0] RST_SRC  = '0;

endpackage : dic_pkg

// ---- inc/dic_req_if.sv ----
// Purpose: carries peripheral requests into and out of the synchroniser
// Assumes: requests may come from other clock domains
// Notes:   clean side is in the pclk domain
`timescale 1ns/1ps
interface dic_req_if;
    import dic_pkg::*;

    logic [SRC_W-1:0] raw_req;
    logic [SRC_W-1:0] clean_req;

    modport sync (input raw_req, output clean_req);
    modport core (output raw_req, input clean_req);
endinterface : dic_req_if

// ---- rtl/dic_sync.sv ----
// Purpose: three-stage synchroniser for peripheral request lines
// Assumes: requests stay stable for several pclk cycles
// Notes:   a bit changes once stages two and three agree
`timescale 1ns/1ps
module dic_sync
    import dic_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    dic_req_if.sync   req
);

    typedef struct packed {
        logic [SRC_W-1:0] s1;
        logic [SRC_W-1:0] s2;
        logic [SRC_W-1:0] s3;
        logic [SRC_W-1:0] out;
    } dic_sync_s;

    dic_sync_s st;
    dic_sync_s next_st;

    always_comb begin
        next_st = st;
        if (ce) begin
            next_st.s1 = req.raw_req;
            next_st.s2 = st.s1;
            next_st.s3 = st.s2;
            for (int i = 0; i < SRC_W; i++) begin
                if (st.s2[i] == st.s3[i]) begin
                    next_st.out[i] = st.s3[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{RST_SRC, RST_SRC, RST_SRC, RST_SRC};
        end else begin
            st <= next_st;
        end
    end

    assign req.clean_req = st.out;

endmodule : dic_sync

// ---- rtl/dic_top.sv ----
// Purpose: two-level interrupt controller with APB register access
// Assumes: one pclk domain, APB master holds a request until pready
// Notes:   status and fast request lag a source change by sync plus one cycle, normal request by sync plus two
`timescale 1ns/1ps
module dic_top
    import dic_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [SRC_W-1:0]  src_req,
    output logic                   normal_request,
    output logic                   fast_request
);

    typedef struct packed {
        logic [31:0] normal_enable_mask;
        logic [31:0] fast_enable_mask;
        logic [1:0]  programmed_interrupt_config;
        logic [31:0] normal_raw_status;
        logic [31:0] fast_raw_status;
        logic [31:0] normal_enabled_status;
        logic [31:0] fast_enabled_status;
        logic        normal_request;
        logic        fast_request;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dic_top_s;

    dic_top_s st;
    dic_top_s next_st;

    dic_req_if req_if ();

    assign req_if.raw_req = src_req;

    dic_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .req     (req_if)
    );

    logic [31:0] src_word;
    logic        fast_or;
    logic        setup_cyc;
    logic        wr_take;
    logic [31:0] wr_en_bits;
    logic [31:0] rd_word;
    logic        rd_hit;

    // Peripheral requests placed at their fixed positions
    always_comb begin
        src_word = '0;
        src_word[SRC_HI:SRC_LO] = req_if.clean_req;
        src_word = src_word & SRC_BITS; // RL16 RL17
    end

    // Next fast bits 31..1, so summary bit and request never lag them
    assign fast_or    = |(src_word[31:1] & st.fast_enable_mask[31:1])
                        | st.programmed_interrupt_config[1]; // RL5
    assign setup_cyc  = psel && !penable && !st.pready;
    assign wr_take    = psel && penable && st.pready && pwrite && !st.pslverr;
    assign wr_en_bits = pwdata & EN_BITS; // RL17

    // Read mux; unmapped offsets answer with an error
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (paddr)
            OFS_NRM_RAW: rd_word = st.normal_raw_status; // RL13
            OFS_NRM_EN:  rd_word = st.normal_enable_mask;
            OFS_NRM_CLR: rd_word = '0; // RL15
            OFS_NRM_STA: rd_word = st.normal_enabled_status; // RL2
            OFS_FST_RAW: rd_word = st.fast_raw_status;
            OFS_FST_EN:  rd_word = st.fast_enable_mask;
            OFS_FST_CLR: rd_word = '0;
            OFS_FST_STA: rd_word = st.fast_enabled_status;
            OFS_PROG: begin
                rd_word[BIT_PROG_FST] = st.programmed_interrupt_config[1];
                rd_word[BIT_PROG_NRM] = st.programmed_interrupt_config[0];
            end
            default:     rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        if (ce) begin
            // APB answer: no wait state, data and error from setup
            next_st.pready = setup_cyc;
            if (setup_cyc) begin
                next_st.prdata  = pwrite ? '0 : rd_word;
                next_st.pslverr = !rd_hit;
            end else if (st.pready) begin
                next_st.prdata  = '0;
                next_st.pslverr = 1'b0;
            end

            if (wr_take) begin
                case (paddr)
                    OFS_NRM_EN: begin
                        next_st.normal_enable_mask =
                            st.normal_enable_mask | wr_en_bits; // RL14
                        next_st.fast_enable_mask =
                            st.fast_enable_mask & ~wr_en_bits; // RL7
                    end
                    OFS_FST_EN: begin
                        next_st.fast_enable_mask =
                            st.fast_enable_mask | wr_en_bits; // RL4
                        next_st.normal_enable_mask =
                            st.normal_enable_mask & ~wr_en_bits; // RL6
                    end
                    OFS_NRM_CLR: begin
                        next_st.normal_enable_mask =
                            st.normal_enable_mask & ~wr_en_bits; // RL15 RL8
                    end
                    OFS_FST_CLR: begin
                        next_st.fast_enable_mask =
                            st.fast_enable_mask & ~wr_en_bits; // RL15 RL8
                    end
                    OFS_PROG: begin
                        next_st.programmed_interrupt_config =
                            {pwdata[BIT_PROG_FST], pwdata[BIT_PROG_NRM]}
                            & PROG_BITS; // RL17
                    end
                    default: begin
                        next_st.programmed_interrupt_config =
                            st.programmed_interrupt_config;
                    end
                endcase
            end

            // Raw status: peripherals, programmed bit, fast summary
            next_st.normal_raw_status = src_word; // RL13
            next_st.normal_raw_status[BIT_PROG] =
                st.programmed_interrupt_config[0]; // RL10
            next_st.normal_raw_status[BIT_FAST_OR] = fast_or; // RL5
            next_st.fast_raw_status = src_word; // RL4
            next_st.fast_raw_status[BIT_PROG] =
                st.programmed_interrupt_config[1]; // RL9
            next_st.fast_raw_status[BIT_FAST_OR] = fast_or; // RL5

            // Enabled status: masked sources, programmed bit unmasked
            next_st.normal_enabled_status =
                src_word & st.normal_enable_mask; // RL1 RL14
            next_st.normal_enabled_status[BIT_PROG] =
                st.programmed_interrupt_config[0]; // RL10 RL11
            next_st.fast_enabled_status =
                src_word & st.fast_enable_mask; // RL4 RL14
            next_st.fast_enabled_status[BIT_PROG] =
                st.programmed_interrupt_config[1]; // RL9 RL11
            next_st.fast_enabled_status[BIT_FAST_OR] = fast_or; // RL5

            next_st.normal_request = |st.normal_enabled_status; // RL3 RL18
            next_st.fast_request   = fast_or; // RL5 RL18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.normal_enable_mask          <= RST_WORD;
            st.fast_enable_mask            <= RST_WORD;
            st.programmed_interrupt_config <= RST_PROG;
            st.normal_raw_status           <= RST_WORD;
            st.fast_raw_status             <= RST_WORD;
            st.normal_enabled_status       <= RST_WORD;
            st.fast_enabled_status         <= RST_WORD;
            st.normal_request              <= 1'b0;
            st.fast_request                <= 1'b0;
            st.prdata                      <= RST_WORD;
            st.pready                      <= 1'b0;
            st.pslverr                     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata         = st.prdata;
    assign pready         = st.pready;
    assign pslverr        = st.pslverr;
    assign normal_request = st.normal_request;
    assign fast_request   = st.fast_request;

endmodule : dic_top

// ---- tb/dic_chk.sv ----
// Purpose: port assertions of the interrupt controller
// Assumes: ce high while checked
// Notes:   bound to dic_top
`timescale 1ns/1ps
module dic_chk
    import dic_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              ce,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              normal_request,
    input wire logic              fast_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd = pready && !pwrite;
    wire logic setup = psel && !penable && ce && !pready;
    property p_beat; pready |=> !pready; endproperty
    a_beat: assert property (p_beat) else $error("pready held");
    property p_ans; setup |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("stray pslverr");
    property p_unmap; setup && paddr > OFS_PROG |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("no error");
    property p_resv; rd |-> (prdata & ~32'h000f_7fbf) == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit");
    property p_clr;
        rd && (paddr == OFS_NRM_CLR || paddr == OFS_FST_CLR) |-> prdata == 0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear port read");
    property p_cfg;
        rd && paddr == OFS_PROG |-> prdata[31:3] == 0 && !prdata[0];
    endproperty
    a_cfg: assert property (p_cfg) else $error("config bits");
    property p_sum; rd && paddr == OFS_FST_STA |-> prdata[0] == |prdata[31:1];
    endproperty
    a_sum: assert property (p_sum) else $error("fast summary");
    property p_nreq;
        rd && paddr == OFS_NRM_STA |-> (prdata != 0) == normal_request;
    endproperty
    a_nreq: assert property (p_nreq) else $error("normal request");
    property p_freq;
        rd && paddr == OFS_FST_STA |-> prdata[0] == $past(fast_request);
    endproperty
    a_freq: assert property (p_freq) else $error("fast request");
    c_err: cover property (pready && pslverr);
    c_nrm: cover property ($rose(normal_request));
    c_fst: cover property ($rose(fast_request));
endmodule : dic_chk
bind dic_top dic_chk dic_chk_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .normal_request(normal_request), .fast_request(fast_request));

// ---- tb/dic_src.sv ----
// Purpose: model of the peripheral request lines
// Assumes: bench names the wanted pattern
// Notes:   each level is held a minimum time
`timescale 1ns/1ps
module dic_src
    import dic_pkg::*;
#(
    parameter int HOLD = 6
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [SRC_W-1:0] want,
    output logic      [SRC_W-1:0] src_req
);
    int age;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_req <= '0;
            age     <= 0;
        end else if (want != src_req && age >= HOLD) begin
            src_req <= want;
            age     <= 0;
        end else if (age < HOLD) begin
            age <= age + 1;
        end
    end
endmodule : dic_src

// ---- tb/tb.sv ----
// Purpose: directed register tests of the interrupt controller
// Assumes: ce high except for one freeze test
// Notes:   fixed settle times after source and config changes
`timescale 1ns/1ps
module tb
    import dic_pkg::*;
;
    logic              pclk, presetn, ce, psel, penable, pwrite;
    logic              pready, pslverr, nreq, freq, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic [SRC_W-1:0]  want, src_req;
    int                miscompares, checked, i;

    dic_src dic_src_i (.pclk(pclk), .presetn(presetn), .want(want),
        .src_req(src_req));
    dic_top dic_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .normal_request(nreq), .fast_request(freq));

    task automatic conclude();
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp
    task automatic cmp1(input logic exp, input logic got);
        cmp({31'h0, exp}, {31'h0, got});
    endtask : cmp1
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, a, 32'h0, q, e);
        cmp(exp, q);
    endtask : rd

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = '0;
        miscompares = 0;
        checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i <= 32; i += 4) rd(8'(i), 32'h0);
        xfer(1'b0, 8'h24, 32'h0, r, er);
        cmp1(1'b1, er);
        wr(OFS_NRM_EN, 32'hffff_ffff);
        rd(OFS_NRM_EN, EN_BITS);
        wr(OFS_FST_EN, 32'h14);
        rd(OFS_FST_EN, 32'h14);
        rd(OFS_NRM_EN, EN_BITS & ~32'h14);
        wr(OFS_NRM_EN, 32'h4);
        rd(OFS_FST_EN, 32'h10);
        wr(OFS_NRM_CLR, 32'h8);
        rd(OFS_NRM_EN, EN_BITS & ~32'h18);
        wr(OFS_FST_CLR, 32'h10);
        rd(OFS_FST_EN, 32'h0);
        want <= '1;
        repeat (16) @(posedge pclk);
        rd(OFS_NRM_RAW, SRC_BITS);
        rd(OFS_NRM_STA, EN_BITS & ~32'h18);
        cmp1(1'b1, nreq);
        cmp1(1'b0, freq);
        wr(OFS_FST_EN, 32'h8);
        repeat (3) @(posedge pclk);
        rd(OFS_FST_STA, 32'h9);
        rd(OFS_NRM_RAW, SRC_BITS | 32'h1);
        cmp1(1'b1, freq);
        wr(OFS_NRM_CLR, 32'hffff_ffff);
        repeat (3) @(posedge pclk);
        rd(OFS_NRM_STA, 32'h0);
        cmp1(1'b0, nreq);
        wr(OFS_PROG, 32'hffff_ffff);
        rd(OFS_PROG, 32'h6);
        repeat (3) @(posedge pclk);
        rd(OFS_NRM_STA, 32'h2);
        rd(OFS_FST_RAW, SRC_BITS | 32'h3);
        cmp1(1'b1, nreq);
        wr(OFS_PROG, 32'h0);
        want <= '0;
        repeat (16) @(posedge pclk);
        rd(OFS_FST_RAW, 32'h0);
        cmp1(1'b0, freq);
        cmp1(1'b0, nreq);
        // Clock enable low: source change must not reach the request
        ce   <= 1'b0;
        want <= '1;
        repeat (16) @(posedge pclk);
        cmp1(1'b0, freq);
        ce <= 1'b1;
        repeat (16) @(posedge pclk);
        cmp1(1'b1, freq);
        rd(OFS_FST_STA, 32'h9);
        conclude();
    end
endmodule : tb
